// ### include/i2c_port_map.vh
// constants for the two-wire slave register port
// Overview of operation
// - clock line is input only; data line is only pulled low or released
// - transaction: start, address plus direction, command byte, data bytes, stop
// - start is data falling with clock high; stop is data rising with clock high
// - idle bus: both lines released and resting high
// - one bit per clock pulse; driver holds data steady while clock high
// - device pulls data low through ninth clock after each received byte
// - match only addresses 0111 x x 0 in the upper seven bits
// - select pin ground, supply, data, clock gives address bits 00, 01, 10, 11
// - direction bit 0 means write, 1 means read
// - watch for start plus matching address, acknowledge, then transfer
// - with timeout enabled, clock edges over 20ms apart abort and release data
// - after timeout abort, ignore the bus until a new start
// - software bit switches the bus timeout on or off
// - first written byte after address loads the register pointer
// - stop right after command byte keeps pointer and writes nothing
// - first data byte goes to the register the pointer selects
// - further data bytes go to following registers by autoincrement
// - timeout is an interrupt source, held until its flag at 0x48 is read
// - pointer holds at 0x00, wraps 0x06 to 0x00, else adds one
// - reads start at the stored pointer and advance after each byte
// - reading the timeout flag register clears the timeout interrupt
// - timeout interrupt enabled by bit 5 of global configuration
`ifndef I2C_PORT_MAP_VH
`define I2C_PORT_MAP_VH
`define ADDR_HIGH_NIBBLE 4'h7
`define REG_FIFO         8'h00
`define REG_AUTOSLEEP    8'h06
`define REG_TIMEOUT_FLAG 8'h48
`define REG_GLOBAL_CFG   8'h40
`define GCFG_TO_INT_BIT  5
`define CLOCK_PERIOD_PS  25000
`define TIMEOUT_MS       20
// 20 ms of 25 ns clocks, written out because the product overflows 32-bit arithmetic
`define TIMEOUT_CYCLES   20'hc3500
`define SEL_GND          2'h0
`define SEL_VCC          2'h1
`define SEL_SDA          2'h2
`define SEL_SCL          2'h3
`endif

// ### design/i2c_slave_register_port.v
// two-wire slave port with command pointer, autoincrement and bus timeout
`timescale 1ns/1ps
`include "i2c_port_map.vh"
module i2c_slave_register_port #(
  parameter [19:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire       clock,
  input  wire       rstn,
  // bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n,
  // address strap: select pin tied to one of four signals
  input  wire       address_select_pin,
  // configuration from the register file
  input  wire       timeout_enable,
  input  wire       timeout_int_enable,
  // register file access
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_write,
  output reg        reg_read,
  input  wire [7:0] reg_rdata,
  // status
  output reg        timeout_flag,
  output reg        timeout_irq,
  output reg        busy
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_RX   = 3'h3;
  localparam [2:0] ST_TX   = 3'h4;
  localparam [2:0] ST_MACK = 3'h5;

  function [7:0] pointer_advance;
    input [7:0] p;
    begin
      if (p == `REG_FIFO)
        pointer_advance = `REG_FIFO;
      else if (p == `REG_AUTOSLEEP)
        pointer_advance = `REG_FIFO;
      else
        pointer_advance = p + 8'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_reg, sda_sync_reg, sel_sync_reg;
  reg       scl_reg, sda_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      // strap rests high like the lines, so a pin tied to a line still matches after reset
      sel_sync_reg <= 2'h3;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      sel_sync_reg <= {sel_sync_reg[0], address_select_pin};
      scl_reg      <= scl_sync_reg[1];
      sda_reg      <= sda_sync_reg[1];
    end
  end
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire sel_s = sel_sync_reg[1];
  wire scl_rise = scl_s & ~scl_reg;
  wire scl_fall = ~scl_s & scl_reg;
  wire start_cond = scl_s & scl_reg & sda_reg & ~sda_s;
  wire stop_cond  = scl_s & scl_reg & ~sda_reg & sda_s;

  // ----------------------------------------------------------------
  // select pin decode
  // ----------------------------------------------------------------
  // the strap is compared against the bus lines while the bus idles high,
  // so a pin following a line is told from a supply tie by watching lows
  reg [1:0] sel_code_reg;
  reg       sel_seen_low_reg, sel_follow_sda_reg, sel_follow_scl_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_code_reg       <= `SEL_GND;
      sel_seen_low_reg   <= 1'b0;
      sel_follow_sda_reg <= 1'b1;
      sel_follow_scl_reg <= 1'b1;
    end else begin
      if (!scl_s || !sda_s || !sel_s)
        sel_seen_low_reg <= 1'b1;
      if (sel_s != sda_s)
        sel_follow_sda_reg <= 1'b0;
      if (sel_s != scl_s)
        sel_follow_scl_reg <= 1'b0;
      if (!sel_s && scl_s && sda_s)
        sel_code_reg <= `SEL_GND;
      else if (sel_seen_low_reg && sel_follow_sda_reg)
        sel_code_reg <= `SEL_SDA;
      else if (sel_seen_low_reg && sel_follow_scl_reg)
        sel_code_reg <= `SEL_SCL;
      else if (sel_s && (!sda_s || !scl_s))
        sel_code_reg <= `SEL_VCC;
    end
  end

  // ----------------------------------------------------------------
  // bus timeout
  // ----------------------------------------------------------------
  reg [19:0] idle_count_reg;
  wire       timeout_hit = timeout_enable && busy && (idle_count_reg >= TIMEOUT_CYCLES);
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      idle_count_reg <= 20'h0;
    else if (scl_rise || scl_fall || !busy)
      idle_count_reg <= 20'h0;
    else if (idle_count_reg != 20'hfffff)
      idle_count_reg <= idle_count_reg + 20'h1;
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg       is_read_reg, have_cmd_reg, ack_addr_reg;
  reg [7:0] pointer_reg;
  wire      addr_match = (shift_reg[7:4] == `ADDR_HIGH_NIBBLE)
                         && (shift_reg[3:2] == sel_code_reg) && !shift_reg[1];

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      is_read_reg  <= 1'b0;
      have_cmd_reg <= 1'b0;
      ack_addr_reg <= 1'b0;
      pointer_reg  <= 8'h00;
      sda_out      <= 1'b0;
      sda_oe_n     <= 1'b1;
      reg_addr     <= 8'h00;
      reg_wdata    <= 8'h00;
      reg_write    <= 1'b0;
      reg_read     <= 1'b0;
      timeout_flag <= 1'b0;
      timeout_irq  <= 1'b0;
      busy         <= 1'b0;
    end else begin
      reg_write <= 1'b0;
      reg_read  <= 1'b0;
      sda_out   <= 1'b0;
      reg_addr  <= pointer_reg;
      // timeout flag: set wins over the read that clears it
      if (timeout_hit) begin
        timeout_flag <= 1'b1;
        timeout_irq  <= timeout_int_enable;
      end else if (reg_read && reg_addr == `REG_TIMEOUT_FLAG) begin
        timeout_flag <= 1'b0;
        timeout_irq  <= 1'b0;
      end
      if (timeout_hit) begin
        state_reg <= ST_IDLE;
        sda_oe_n  <= 1'b1;
        busy      <= 1'b0;
      end else if (start_cond) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_n    <= 1'b1;
        busy        <= 1'b1;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_oe_n  <= 1'b1;
        busy      <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (addr_match) begin
                  sda_oe_n     <= 1'b0;
                  is_read_reg  <= shift_reg[0];
                  have_cmd_reg <= 1'b0;
                  ack_addr_reg <= 1'b1;
                  state_reg    <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                sda_oe_n     <= 1'b0;
                ack_addr_reg <= 1'b0;
                state_reg    <= ST_ACK;
                if (!have_cmd_reg) begin
                  pointer_reg  <= shift_reg;
                  have_cmd_reg <= 1'b1;
                end else begin
                  reg_addr    <= pointer_reg;
                  reg_wdata   <= shift_reg;
                  reg_write   <= 1'b1;
                  pointer_reg <= pointer_advance(pointer_reg);
                end
              end
            end
          end
          ST_ACK: begin
            // the ack stays low across the ninth high phase and ends on its fall
            if (scl_fall) begin
              if (ack_addr_reg && is_read_reg) begin
                shift_reg   <= reg_rdata;
                reg_read    <= 1'b1;
                pointer_reg <= pointer_advance(pointer_reg);
                sda_oe_n    <= reg_rdata[7];
                bit_cnt_reg <= 4'h1;
                state_reg   <= ST_TX;
              end else begin
                sda_oe_n  <= 1'b1;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                sda_oe_n  <= 1'b1;
                state_reg <= ST_MACK;
              end else begin
                sda_oe_n    <= shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_s)
                state_reg <= ST_IDLE;
              else
                ack_addr_reg <= 1'b1;
            end else if (scl_fall && ack_addr_reg) begin
              shift_reg   <= reg_rdata;
              reg_read    <= 1'b1;
              pointer_reg <= pointer_advance(pointer_reg);
              sda_oe_n    <= reg_rdata[7];
              bit_cnt_reg <= 4'h1;
              state_reg   <= ST_TX;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### tb/bus_master_model.sv
// two-wire bus master model that clocks the slave port from the bench
`timescale 1ns/1ps
module bus_master_model (
  // system clock and resolved data wire
  input  wire clock,
  input  wire sda_line,
  // driven lines, data open-drain style: 1 means released
  output reg  scl,
  output reg  sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  // ----
  // bit level: data set mid low phase, held through high, sampled at its end
  // ----
  task automatic pulse(input logic b, output logic s);
    scl <= 1'b0;
    w(2);
    sda <= b;
    w(2);
    scl <= 1'b1;
    w(4);
    s = sda_line;
  endtask
  // also serves as repeated start: data rises while clock low first
  task automatic start();
    scl <= 1'b0;
    w(2);
    sda <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(4);
    sda <= 1'b0;
    w(4);
  endtask
  task automatic stop();
    scl <= 1'b0;
    w(2);
    sda <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1;
    w(4);
  endtask
  task automatic stall(input int n);
    scl <= 1'b0;
    w(n);
  endtask
  // ----
  // byte level, msb first, ninth pulse always from the master
  // ----
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(d[i], s);
    pulse(1'b1, ack);
  endtask
  task automatic byte_rd(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(nak, s);
  endtask
endmodule

// ### tb/i2c_port_checker_asserts.sv
// assertions on the pins of the two-wire slave register port
`timescale 1ns/1ps
`include "i2c_port_map.vh"
module i2c_port_checker #(
  parameter [19:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  // clock, reset and bus pins
  input wire       clock,
  input wire       rstn,
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe_n,
  // configuration, register access and status
  input wire       timeout_enable,
  input wire       timeout_int_enable,
  input wire [7:0] reg_addr,
  input wire       reg_write,
  input wire       reg_read,
  input wire       timeout_flag,
  input wire       timeout_irq,
  input wire       busy
);
  logic        scl_q;
  logic [19:0] idle_cnt;
  // cycles since the raw clock line last moved; the port lags it, so it only sees less
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      idle_cnt <= 20'h0;
    end else begin
      scl_q <= scl_in;
      idle_cnt <= (scl_in != scl_q) ? 20'h0 : idle_cnt + 20'h1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_released;
    ##[0:2] (sda_oe_n && !busy);
  endsequence
  property p_pull_only;
    sda_out == 1'b0;
  endproperty
  property p_steady_high;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  property p_write_busy;
    reg_write |-> busy && !reg_read;
  endproperty
  property p_write_pulse;
    reg_write |=> !reg_write;
  endproperty
  property p_read_pulse;
    reg_read |=> !reg_read;
  endproperty
  property p_irq_flag;
    timeout_irq |-> timeout_flag;
  endproperty
  property p_irq_enable;
    $rose(timeout_irq) |-> timeout_int_enable;
  endproperty
  property p_timeout_cause;
    $rose(timeout_flag) |-> timeout_enable && idle_cnt >= TIMEOUT_CYCLES;
  endproperty
  property p_abort;
    $rose(timeout_flag) |-> s_released;
  endproperty
  property p_flag_clear;
    reg_read && reg_addr == `REG_TIMEOUT_FLAG |=> !timeout_flag && !timeout_irq;
  endproperty
  a_pull_only: assert property (p_pull_only) else $error("data pin driven high");
  a_steady_high: assert property (p_steady_high) else $error("data moved while clock high");
  a_write_busy: assert property (p_write_busy) else $error("write outside transfer");
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse too long");
  a_read_pulse: assert property (p_read_pulse) else $error("read pulse too long");
  a_irq_flag: assert property (p_irq_flag) else $error("interrupt without flag");
  a_irq_enable: assert property (p_irq_enable) else $error("interrupt while disabled");
  a_timeout_cause: assert property (p_timeout_cause) else $error("early or disabled timeout");
  a_abort: assert property (p_abort) else $error("no release on timeout");
  a_flag_clear: assert property (p_flag_clear) else $error("flag survived read");
endmodule
bind i2c_slave_register_port i2c_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) checker_i (
  .clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .timeout_enable(timeout_enable), .timeout_int_enable(timeout_int_enable), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .timeout_flag(timeout_flag), .timeout_irq(timeout_irq), .busy(busy));

// ### tb/tb_top.sv
// self-checking bench for the two-wire slave register port
`timescale 1ns/1ps
module tb_top;
  logic        clock, rstn, to_en, to_int_en, scl, sda_m;
  logic [1:0]  strap_mode;
  logic        sda_out, sda_oe_n, reg_write, reg_read, timeout_flag, timeout_irq, busy;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [15:0] wq[$];
  logic        a, acc;
  int          bad_count = 0;
  int          compares = 0;
  // pulled-up wire; read data is a bench pattern of the address
  wire         sda_line = sda_m & (sda_oe_n | sda_out);
  // strap modes: ground, supply, data line, clock line
  wire         strap_pin = (strap_mode == 2'h2) ? sda_line : (strap_mode == 2'h3) ? scl : strap_mode[0];
  assign reg_rdata = reg_addr ^ 8'h5a;
  bus_master_model m (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(sda_m));
  i2c_slave_register_port #(.TIMEOUT_CYCLES(20'h0c8)) dut (
    .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_pin(strap_pin), .timeout_enable(to_en), .timeout_int_enable(to_int_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timeout_flag(timeout_flag), .timeout_irq(timeout_irq), .busy(busy));
  always @(posedge clock) if (reg_write === 1'b1) wq.push_back({reg_addr, reg_wdata});
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // ----
  // scenarios; strap tied to ground gives address 0x38
  // ----
  task automatic t_write();
    wq.delete();
    m.start();
    m.byte_wr(8'h70, acc);
    m.byte_wr(8'h05, a);
    for (int i = 0; i < 4; i++) begin
      acc |= a;
      m.byte_wr(8'ha1 + i, a);
    end
    m.stop();
    chk((acc | a) === 1'b0, "byte not acked");
    chk(wq.size() == 4 && wq[0] === 16'h05a1 && wq[1] === 16'h06a2, "write order");
    chk(wq.size() == 4 && wq[2] === 16'h00a3 && wq[3] === 16'h00a4, "wrap and hold");
    $display("test write done");
  endtask
  task automatic t_read();
    wq.delete();
    m.start();
    m.byte_wr(8'h70, a);
    m.byte_wr(8'h47, a);
    m.stop();
    chk(wq.size() == 0, "register changed by command");
    m.start();
    m.byte_wr(8'h71, a);
    m.byte_rd(1'b0, d);
    chk(d === (8'h47 ^ 8'h5a), "first read byte");
    m.byte_rd(1'b1, d);
    chk(d === (8'h48 ^ 8'h5a), "second read byte");
    m.byte_rd(1'b1, d);
    chk(d === 8'hff, "data after not-ack");
    m.stop();
    $display("test read done");
  endtask
  task automatic t_badaddr();
    logic [7:0] bad [3] = '{8'h72, 8'h60, 8'h74};
    for (int i = 0; i < 3; i++) begin
      m.start();
      m.byte_wr(bad[i], a);
      chk(a === 1'b1, "foreign address acked");
    end
    m.stop();
    $display("test address done");
  endtask
  task automatic t_timeout();
    m.start();
    m.byte_wr(8'h70, a);
    m.stall(300);
    chk(timeout_flag === 1'b0, "timeout while disabled");
    m.stop();
    to_en <= 1'b1;
    m.start();
    m.byte_wr(8'h71, a);
    m.stall(300);
    chk(timeout_flag === 1'b1 && timeout_irq === 1'b1, "no timeout");
    chk(sda_oe_n === 1'b1 && busy === 1'b0, "not released");
    m.byte_wr(8'h70, a);
    chk(a === 1'b1, "acked without start");
    m.start();
    m.byte_wr(8'h70, a);
    m.byte_wr(8'h48, a);
    chk(timeout_irq === 1'b1, "interrupt dropped before flag read");
    m.start();
    m.byte_wr(8'h71, a);
    m.byte_rd(1'b1, d);
    m.stop();
    chk(d === (8'h48 ^ 8'h5a) && timeout_flag === 1'b0 && timeout_irq === 1'b0, "flag not cleared");
    to_int_en <= 1'b0;
    m.start();
    m.byte_wr(8'h71, a);
    m.stall(300);
    chk(timeout_flag === 1'b1 && timeout_irq === 1'b0, "interrupt while disabled");
    m.stop();
    $display("test timeout done");
  endtask
  // mid-run reset per non-ground strap mode (supply, data line, clock line); the ground address must then be refused
  task automatic t_strap();
    logic [7:0] own [3] = '{8'h74, 8'h78, 8'h7c};
    for (int i = 0; i < 3; i++) begin
      strap_mode <= i[1:0] + 2'h1;
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (10) @(posedge clock);
      chk(sda_oe_n === 1'b1 && busy === 1'b0 && timeout_flag === 1'b0, "state after reset");
      m.start();
      m.byte_wr(8'h70, a);
      chk(a === 1'b1, "ground address acked");
      m.start();
      m.byte_wr(own[i], a);
      chk(a === 1'b0, "strapped address not acked");
      m.stop();
    end
    $display("test strap done");
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    strap_mode = 2'h0;
    to_en = 1'b0;
    to_int_en = 1'b1;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (20) @(posedge clock);
    t_write();
    t_read();
    t_badaddr();
    t_timeout();
    t_strap();
    summarize();
  end
  // the five scenarios need well under 10000 cycles
  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule
